/* File: inc/atc_defs.svh */
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH

// Register indices; byte address is four times the index
`define ATC_IDX_FLAGS        10'h037
`define ATC_IDX_MASK         10'h070
`define ATC_IDX_CTRL_A       10'h0b0
`define ATC_IDX_CTRL_B       10'h0b1
`define ATC_IDX_COUNTER      10'h0b2
`define ATC_IDX_CMP_A        10'h0b3
`define ATC_IDX_CMP_B        10'h0b4
`define ATC_IDX_ASYNC        10'h0b6

// Control A fields
`define ATC_ACT_A_MSB        7
`define ATC_ACT_A_LSB        6
`define ATC_ACT_B_MSB        5
`define ATC_ACT_B_LSB        4
`define ATC_WGM_LO_MSB       1
`define ATC_WGM_LO_LSB       0
`define ATC_CTRL_A_RD_MASK   8'hf3

// Control B fields
`define ATC_FORCE_A_BIT      7
`define ATC_FORCE_B_BIT      6
`define ATC_WGM_HIGH_BIT     3
`define ATC_CS_MSB           2
`define ATC_CS_LSB           0
`define ATC_CTRL_B_RD_MASK   8'h0f

// Async status fields; busy bits 4..0 follow the slot numbering below
`define ATC_EXT_CLK_BIT      6
`define ATC_ASYNC_SEL_BIT    5
`define ATC_SLOT_CTRL_B      0
`define ATC_SLOT_CTRL_A      1
`define ATC_SLOT_CMP_B       2
`define ATC_SLOT_CMP_A       3
`define ATC_SLOT_COUNTER     4

// Flag and mask bits
`define ATC_BIT_OVF          0
`define ATC_BIT_MATCH_A      1
`define ATC_BIT_MATCH_B      2
`define ATC_FLAG_MASK        8'h07

// Reset value and counter limits
`define ATC_RESET_VAL        8'h00
`define ATC_COUNT_MAX        8'hff
`define ATC_COUNT_BOTTOM     8'h00

// Prescaler taps as powers of two: 8, 32, 64, 128, 256, 1024
`define ATC_TAP_DIV8         3
`define ATC_TAP_DIV32        5
`define ATC_TAP_DIV64        6
`define ATC_TAP_DIV128       7
`define ATC_TAP_DIV256       8
`define ATC_TAP_DIV1024      10

`endif

/* File: inc/atc_pkg.sv */
package atc_pkg;

   // Counting behaviour decoded from the three waveform mode bits
   typedef enum logic [1:0] {
      ATC_NORMAL,
      ATC_CTC,
      ATC_FAST_PWM,
      ATC_PHASE_PWM
   } atc_kind_e;

   typedef logic [7:0] atc_byte_t;

endpackage : atc_pkg

/* File: hdl/atc_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "atc_defs.svh"

module atc_prescaler #(
   parameter int PRESC_W = 10
) (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Source tick and selection
   input  wire logic       src_tick,
   input  wire logic [2:0] clock_select_field,
   // Count enable for the timer
   output logic            count_tick
);

   logic [PRESC_W-1:0] presc_reg;
   logic               tap_hit;

   initial begin
      if (PRESC_W < `ATC_TAP_DIV1024) begin
         $error("atc_prescaler: PRESC_W too small for the largest division");
      end
   end

   // True when the low n bits of the prescaler are all ones
   function automatic logic low_ones(input logic [PRESC_W-1:0] v, input int n);
      logic r;
      r = 1'b1;
      for (int i = 0; i < n; i++) begin
         r = r & v[i];
      end
      return r;
   endfunction : low_ones

   // Free running divider; it advances only on source ticks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_reg <= '0;
      end else if (src_tick) begin
         presc_reg <= presc_reg + 1'b1;
      end
   end

   // Tap selection from the clock select code
   always_comb begin
      case (clock_select_field)
         3'h0:    tap_hit = 1'b0;                                  // RULE7
         3'h1:    tap_hit = 1'b1;                                  // RULE7
         3'h2:    tap_hit = low_ones(presc_reg, `ATC_TAP_DIV8);    // RULE7
         3'h3:    tap_hit = low_ones(presc_reg, `ATC_TAP_DIV32);   // RULE7
         3'h4:    tap_hit = low_ones(presc_reg, `ATC_TAP_DIV64);   // RULE7
         3'h5:    tap_hit = low_ones(presc_reg, `ATC_TAP_DIV128);  // RULE7
         3'h6:    tap_hit = low_ones(presc_reg, `ATC_TAP_DIV256);  // RULE7
         default: tap_hit = low_ones(presc_reg, `ATC_TAP_DIV1024); // RULE7
      endcase
   end

   assign count_tick = src_tick & tap_hit;

endmodule : atc_prescaler
`default_nettype wire

/* File: hdl/atc_timer.sv */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "atc_defs.svh"

// Contract
// RULE1: Force bits act only in non-PWM modes; ignored in PWM modes.
// RULE2: Writing a force bit makes an immediate match acting per output action.
// RULE3: Software keeps force bits zero when writing control B in PWM modes.
// RULE4: A forced match sets no flag and never clears the counter.
// RULE5: Force bits always read back as zero.
// RULE6: Control B bits 5 and 4 always read as zero.
// RULE7: Clock select: stop, undivided, then divide by 8,32,64,128,256,1024.
// RULE8: Counter readable and writable; a write blocks the next timer clock match.
// RULE9: Both compare registers continuously compared with counter for flag and output.
// RULE10: External clock buffer used when enabled in async mode; crystal only otherwise.
// RULE11: Software sets external clock enable before selecting async operation.
// RULE12: Async select zero counts bus clock; one counts the oscillator pin.
// RULE13: Software rewrites timer registers after changing async select.
// RULE14: Async writes set per-register busy bits, cleared once copied from holding.
// RULE15: Software does not write a register while its busy bit is set.
// RULE16: Counter reads live value; compares and controls read holding storage.
// RULE17: Interrupt runs only when mask bit, global enable and flag are all one.
// RULE18: Async status: bit 7 zero, bits 6:5 writable, 4:0 read-only, reset zero.
// RULE19: Flags set on compare matches and overflow; phase PWM overflow at bottom.
// RULE20: Flags cleared by vector execution or by writing one.
// RULE21: High mode bit joins the two low mode bits to pick the waveform mode.
module atc_timer #(
   parameter int PRESC_W = 10
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Timer pins
   input  wire logic        async_osc_pin,
   output logic             wave_out_a,
   output logic             wave_out_b,
   output logic             wave_drive_a,
   output logic             wave_drive_b,
   output logic             xtal_osc_enable,
   output logic             ext_clock_buffer_enable,
   // Interrupt handshake with the processor core
   input  wire logic        global_irq_enable,
   input  wire logic        vector_ack_a,
   input  wire logic        vector_ack_b,
   input  wire logic        vector_ack_ovf,
   output logic             irq_match_a,
   output logic             irq_match_b,
   output logic             irq_overflow
);

   // Bus pipeline state
   logic                  ph_valid_reg;
   logic                  ph_write_reg;
   logic [9:0]            ph_idx_reg;
   logic [31:0]           hrdata_reg;
   logic                  hreadyout_reg;
   logic                  hresp_reg;
   // Timer registers: holding copies and the live copies the timer uses
   atc_pkg::atc_byte_t    hold_reg [5];
   atc_pkg::atc_byte_t    ctl_a_reg;
   atc_pkg::atc_byte_t    ctl_b_reg;
   atc_pkg::atc_byte_t    cmp_a_reg;
   atc_pkg::atc_byte_t    cmp_b_reg;
   atc_pkg::atc_byte_t    cnt_reg;
   atc_pkg::atc_byte_t    cnt_next;
   logic [4:0]            busy_reg;
   logic [4:0]            busy_next;
   logic                  ext_clk_reg;
   logic                  async_sel_reg;
   logic [2:0]            mask_reg;
   logic [2:0]            flags_reg;
   logic [2:0]            flags_next;
   logic                  dir_down_reg;
   logic                  dir_down_next;
   logic                  block_reg;
   logic                  osc_prev_reg;
   logic                  wave_a_reg;
   logic                  wave_b_reg;
   logic                  drive_a_reg;
   logic                  drive_b_reg;
   logic                  xtal_en_reg;
   logic                  ext_buf_reg;
   logic                  irq_a_reg;
   logic                  irq_b_reg;
   logic                  irq_ovf_reg;
   logic                  ovf_evt;
   logic                  wrap_evt;

   initial begin
      if (PRESC_W < `ATC_TAP_DIV1024) begin
         $error("atc_timer: PRESC_W too small for the largest division");
      end
   end

   // Address phase decode; only whole-word writes take effect, reads of any size are answered
   wire        addr_take = hsel & htrans[1] & hready;
   wire        wr_valid  = ph_valid_reg & ph_write_reg;
   wire [7:0]  wdata8    = hwdata[7:0];
   wire        wr_flags  = wr_valid && (ph_idx_reg == `ATC_IDX_FLAGS);
   wire        wr_mask   = wr_valid && (ph_idx_reg == `ATC_IDX_MASK);
   wire        wr_async  = wr_valid && (ph_idx_reg == `ATC_IDX_ASYNC);
   wire        wr_ctl_a  = wr_valid && (ph_idx_reg == `ATC_IDX_CTRL_A);
   wire        wr_ctl_b  = wr_valid && (ph_idx_reg == `ATC_IDX_CTRL_B);
   wire        wr_cnt    = wr_valid && (ph_idx_reg == `ATC_IDX_COUNTER);
   wire        wr_cmp_a  = wr_valid && (ph_idx_reg == `ATC_IDX_CMP_A);
   wire        wr_cmp_b  = wr_valid && (ph_idx_reg == `ATC_IDX_CMP_B);
   wire [4:0]  wr_vec    = {wr_cnt, wr_cmp_a, wr_cmp_b, wr_ctl_a, wr_ctl_b};

   // Timer clock source: every bus clock, or a rising edge on the oscillator pin
   wire        osc_edge  = async_osc_pin & ~osc_prev_reg;
   wire        src_tick  = async_sel_reg ? osc_edge : 1'b1;                 // RULE12

   // A slot copies at the write in sync mode, at the next source tick in async mode
   wire [4:0]  upd_vec   = async_sel_reg ? (busy_reg & {5{src_tick}} & ~wr_vec) : wr_vec;

   // Mode decode from the three mode bits
   wire [2:0]  wgm       = {ctl_b_reg[`ATC_WGM_HIGH_BIT],
                            ctl_a_reg[`ATC_WGM_LO_MSB:`ATC_WGM_LO_LSB]};      // RULE21
   wire atc_pkg::atc_kind_e kind = kind_of(wgm);
   wire        top_is_a  = (wgm == 3'h2) || (wgm == 3'h5) || (wgm == 3'h7); // RULE21
   wire [7:0]  top_val   = top_is_a ? cmp_a_reg : `ATC_COUNT_MAX;
   wire        non_pwm   = (kind == atc_pkg::ATC_NORMAL) || (kind == atc_pkg::ATC_CTC);
   wire [1:0]  act_a     = ctl_a_reg[`ATC_ACT_A_MSB:`ATC_ACT_A_LSB];
   wire [1:0]  act_b     = ctl_a_reg[`ATC_ACT_B_MSB:`ATC_ACT_B_LSB];
   wire        wgm_high  = ctl_b_reg[`ATC_WGM_HIGH_BIT];

   // Force strobes act on the written value and only outside PWM modes
   wire        force_a   = wr_ctl_b & wdata8[`ATC_FORCE_A_BIT] & non_pwm;     // RULE1
   wire        force_b   = wr_ctl_b & wdata8[`ATC_FORCE_B_BIT] & non_pwm;     // RULE1

   wire        count_tick;
   wire        copy_cnt  = upd_vec[`ATC_SLOT_COUNTER];
   // Matches are suppressed for one timer clock after a counter update
   wire        match_a   = count_tick & ~copy_cnt & ~block_reg & (cnt_reg == cmp_a_reg); // RULE9
   wire        match_b   = count_tick & ~copy_cnt & ~block_reg & (cnt_reg == cmp_b_reg); // RULE9

   // Decode the mode bits into a counting behaviour; reserved codes count as normal
   function automatic atc_pkg::atc_kind_e kind_of(input logic [2:0] w);
      atc_pkg::atc_kind_e k;
      case (w)
         3'h1, 3'h5: k = atc_pkg::ATC_PHASE_PWM;
         3'h2:       k = atc_pkg::ATC_CTC;
         3'h3, 3'h7: k = atc_pkg::ATC_FAST_PWM;
         default:    k = atc_pkg::ATC_NORMAL;
      endcase
      return k;
   endfunction : kind_of

   // Next level of a waveform output; used for both channels
   function automatic logic wave_step(input atc_pkg::atc_kind_e k, input logic [1:0] act,
                                      input logic toggle_ok, input logic hit,
                                      input logic bottom, input logic down,
                                      input logic cur);
      logic r;
      r = cur;
      case (k)
         atc_pkg::ATC_FAST_PWM: begin
            if (hit) begin
               if (act == 2'h1 && toggle_ok) r = ~cur;
               else if (act == 2'h2) r = 1'b0;
               else if (act == 2'h3) r = 1'b1;
            end else if (bottom) begin
               if (act == 2'h2) r = 1'b1;
               else if (act == 2'h3) r = 1'b0;
            end
         end
         atc_pkg::ATC_PHASE_PWM: begin
            if (hit) begin
               if (act == 2'h1 && toggle_ok) r = ~cur;
               else if (act == 2'h2) r = down;
               else if (act == 2'h3) r = ~down;
            end
         end
         default: begin
            if (hit) begin
               if (act == 2'h1) r = ~cur;
               else if (act == 2'h2) r = 1'b0;
               else if (act == 2'h3) r = 1'b1;
            end
         end
      endcase
      return r;
   endfunction : wave_step

   // Read mux: live counter, holding storage for compares and controls
   function automatic logic [7:0] read_mux(input logic [9:0] idx);
      logic [7:0] r;
      r = 8'h00;
      if (idx == `ATC_IDX_COUNTER) r = cnt_reg;                                 // RULE16
      else if (idx == `ATC_IDX_CMP_A) r = hold_reg[`ATC_SLOT_CMP_A];            // RULE16
      else if (idx == `ATC_IDX_CMP_B) r = hold_reg[`ATC_SLOT_CMP_B];            // RULE16
      else if (idx == `ATC_IDX_CTRL_A) r = hold_reg[`ATC_SLOT_CTRL_A] & `ATC_CTRL_A_RD_MASK;
      else if (idx == `ATC_IDX_CTRL_B)
         r = hold_reg[`ATC_SLOT_CTRL_B] & `ATC_CTRL_B_RD_MASK;                 // RULE5 RULE6
      else if (idx == `ATC_IDX_ASYNC) r = {1'b0, ext_clk_reg, async_sel_reg, busy_reg}; // RULE18
      else if (idx == `ATC_IDX_FLAGS) r = {5'h00, flags_reg};
      else if (idx == `ATC_IDX_MASK) r = {5'h00, mask_reg};
      return r;
   endfunction : read_mux

   atc_prescaler #(
      .PRESC_W            (PRESC_W)
   ) u_presc (
      .hclk               (hclk),
      .hresetn            (hresetn),
      .src_tick           (src_tick),
      .clock_select_field (ctl_b_reg[`ATC_CS_MSB:`ATC_CS_LSB]),
      .count_tick         (count_tick)
   );

   // Counter step; a counter load (write data in sync mode, holding storage in async mode) wins over counting
   always_comb begin
      cnt_next      = cnt_reg;
      dir_down_next = dir_down_reg;
      ovf_evt       = 1'b0;
      wrap_evt      = 1'b0;
      if (copy_cnt) begin
         cnt_next = async_sel_reg ? hold_reg[`ATC_SLOT_COUNTER] : wdata8;      // RULE8
      end else if (count_tick) begin
         if (kind == atc_pkg::ATC_PHASE_PWM) begin
            if (!dir_down_reg) begin
               if (cnt_reg == top_val) begin
                  dir_down_next = 1'b1;
                  cnt_next      = cnt_reg - 8'h01;
               end else begin
                  cnt_next = cnt_reg + 8'h01;
               end
            end else if (cnt_reg == `ATC_COUNT_BOTTOM) begin
               dir_down_next = 1'b0;
               ovf_evt       = 1'b1;                                         // RULE19
               cnt_next      = cnt_reg + 8'h01;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end else begin
            wrap_evt = (cnt_reg == top_val);
            cnt_next = wrap_evt ? `ATC_COUNT_BOTTOM : cnt_reg + 8'h01;
            ovf_evt  = (kind == atc_pkg::ATC_FAST_PWM) ? wrap_evt
                                                       : (cnt_reg == `ATC_COUNT_MAX); // RULE19
         end
      end
   end

   // Flag update: hardware set wins over a clear in the same cycle
   always_comb begin
      flags_next = flags_reg;
      if (wr_flags) flags_next = flags_next & ~wdata8[2:0];                      // RULE20
      if (vector_ack_ovf) flags_next[`ATC_BIT_OVF] = 1'b0;                       // RULE20
      if (vector_ack_a) flags_next[`ATC_BIT_MATCH_A] = 1'b0;                     // RULE20
      if (vector_ack_b) flags_next[`ATC_BIT_MATCH_B] = 1'b0;                     // RULE20
      // Forced matches never reach the flags
      flags_next = flags_next | {match_b, match_a, ovf_evt};                     // RULE4 RULE19
   end

   // Busy bits only exist in async mode; a new write re-arms the bit
   assign busy_next = async_sel_reg ? ((busy_reg & ~{5{src_tick}}) | wr_vec) : 5'h00; // RULE14

   // Bus address phase capture and registered answer, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_reg  <= 1'b0;
         ph_write_reg  <= 1'b0;
         ph_idx_reg    <= 10'h000;
         hrdata_reg    <= 32'h0000_0000;
         hreadyout_reg <= 1'b1;
         hresp_reg     <= 1'b0;
      end else begin
         ph_valid_reg  <= addr_take && (hsize == 3'h2);
         ph_write_reg  <= hwrite;
         ph_idx_reg    <= haddr[11:2];
         hrdata_reg    <= (addr_take && !hwrite) ? {24'h000000, read_mux(haddr[11:2])}
                                                 : 32'h0000_0000;
         hreadyout_reg <= 1'b1;
         hresp_reg     <= 1'b0;
      end
   end

   // Holding storage keeps every written byte whole; reserved and strobe bits are masked on read and on the copy into the live controls
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 5; i++) begin
            hold_reg[i] <= `ATC_RESET_VAL;
         end
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (wr_vec[i]) hold_reg[i] <= wdata8;
         end
      end
   end

   // Live timer registers, loaded as their slot updates
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_a_reg <= `ATC_RESET_VAL;
         ctl_b_reg <= `ATC_RESET_VAL;
         cmp_a_reg <= `ATC_RESET_VAL;
         cmp_b_reg <= `ATC_RESET_VAL;
      end else begin
         if (upd_vec[`ATC_SLOT_CTRL_A])
            ctl_a_reg <= (async_sel_reg ? hold_reg[`ATC_SLOT_CTRL_A] : wdata8) & `ATC_CTRL_A_RD_MASK;
         if (upd_vec[`ATC_SLOT_CTRL_B])
            ctl_b_reg <= (async_sel_reg ? hold_reg[`ATC_SLOT_CTRL_B] : wdata8) & `ATC_CTRL_B_RD_MASK;
         if (upd_vec[`ATC_SLOT_CMP_A])
            cmp_a_reg <= async_sel_reg ? hold_reg[`ATC_SLOT_CMP_A] : wdata8;
         if (upd_vec[`ATC_SLOT_CMP_B])
            cmp_b_reg <= async_sel_reg ? hold_reg[`ATC_SLOT_CMP_B] : wdata8;
      end
   end

   // Counter, direction and the one-tick match block after a counter write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg      <= `ATC_RESET_VAL;
         dir_down_reg <= 1'b0;
         block_reg    <= 1'b0;
      end else begin
         cnt_reg      <= cnt_next;
         dir_down_reg <= dir_down_next;
         block_reg    <= copy_cnt | (block_reg & ~count_tick);                  // RULE8
      end
   end

   // Status, mask, flags and busy bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_clk_reg   <= 1'b0;
         async_sel_reg <= 1'b0;
         busy_reg      <= 5'h00;
         mask_reg      <= 3'h0;
         flags_reg     <= 3'h0;
         osc_prev_reg  <= 1'b0;
      end else begin
         if (wr_async) begin
            ext_clk_reg   <= wdata8[`ATC_EXT_CLK_BIT];                          // RULE18
            async_sel_reg <= wdata8[`ATC_ASYNC_SEL_BIT];                        // RULE18
         end
         if (wr_mask) mask_reg <= wdata8[2:0];
         busy_reg     <= busy_next;                                             // RULE14
         flags_reg    <= flags_next;
         osc_prev_reg <= async_osc_pin;
      end
   end

   // Waveform outputs; forced matches act through the same output action
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave_a_reg  <= 1'b0;
         wave_b_reg  <= 1'b0;
         drive_a_reg <= 1'b0;
         drive_b_reg <= 1'b0;
      end else begin
         wave_a_reg  <= wave_step(kind, act_a, wgm_high, match_a | force_a, wrap_evt,
                                  dir_down_reg, wave_a_reg);                    // RULE2 RULE9
         wave_b_reg  <= wave_step(kind, act_b, 1'b0, match_b | force_b, wrap_evt,
                                  dir_down_reg, wave_b_reg);                    // RULE2 RULE9
         drive_a_reg <= (act_a != 2'h0);
         drive_b_reg <= (act_b != 2'h0);
      end
   end

   // Oscillator control and gated interrupt requests
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xtal_en_reg <= 1'b0;
         ext_buf_reg <= 1'b0;
         irq_a_reg   <= 1'b0;
         irq_b_reg   <= 1'b0;
         irq_ovf_reg <= 1'b0;
      end else begin
         xtal_en_reg <= async_sel_reg & ~ext_clk_reg;                            // RULE10
         ext_buf_reg <= async_sel_reg & ext_clk_reg;                             // RULE10
         irq_a_reg   <= global_irq_enable & mask_reg[`ATC_BIT_MATCH_A] & flags_next[`ATC_BIT_MATCH_A]; // RULE17
         irq_b_reg   <= global_irq_enable & mask_reg[`ATC_BIT_MATCH_B] & flags_next[`ATC_BIT_MATCH_B]; // RULE17
         irq_ovf_reg <= global_irq_enable & mask_reg[`ATC_BIT_OVF] & flags_next[`ATC_BIT_OVF];         // RULE17
      end
   end

   // Every output straight from a flip-flop
   assign hrdata                  = hrdata_reg;
   assign hreadyout               = hreadyout_reg;
   assign hresp                   = hresp_reg;
   assign wave_out_a              = wave_a_reg;
   assign wave_out_b              = wave_b_reg;
   assign wave_drive_a            = drive_a_reg;
   assign wave_drive_b            = drive_b_reg;
   assign xtal_osc_enable         = xtal_en_reg;
   assign ext_clock_buffer_enable = ext_buf_reg;
   assign irq_match_a             = irq_a_reg;
   assign irq_match_b             = irq_b_reg;
   assign irq_overflow            = irq_ovf_reg;

endmodule : atc_timer
`default_nettype wire

/* File: dv/atc_timer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "atc_defs.svh"
module atc_chk (
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hrdata,
   // Interrupt requests
   input wire logic        global_irq_enable,
   input wire logic        irq_match_a,
   input wire logic        irq_match_b,
   input wire logic        irq_overflow
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Read address phase; hready is left out since the slave never stalls
   wire       rd  = hsel && htrans[1] && !hwrite;
   wire [9:0] ix  = haddr[11:2];
   wire       irq = irq_match_a || irq_match_b || irq_overflow;
   a_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
   a_idle_zero: assert property (!rd |=> hrdata == 32'h0) else $error("data outside read");
   a_ctrl_b_read: assert property (rd && ix == `ATC_IDX_CTRL_B |=> !hrdata[7:4])
      else $error("control B high bits set");
   a_async_msb: assert property (rd && ix == `ATC_IDX_ASYNC |=> !hrdata[7])
      else $error("async bit 7 set");
   a_flags_upper: assert property (rd && ix == `ATC_IDX_FLAGS |=> !hrdata[7:3])
      else $error("flag high bits set");
   a_ctrl_a_gap: assert property (rd && ix == `ATC_IDX_CTRL_A |=> !hrdata[3:2])
      else $error("control A gap bits set");
   a_irq_global: assert property (irq |-> $past(global_irq_enable))
      else $error("request without global enable");
   a_irq_fall: assert property ($fell(global_irq_enable) |=> !irq)
      else $error("request after global disable");
   // Main scenarios
   cover property (irq_match_a);
   cover property ($fell(global_irq_enable));
   cover property (rd && ix == `ATC_IDX_CTRL_B);
endmodule : atc_chk

bind atc_timer atc_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hrdata,
   .global_irq_enable, .irq_match_a, .irq_match_b, .irq_overflow);
`default_nettype wire

/* File: dv/test_async_timer2_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "atc_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_async_timer2_control_regs;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, osc = 1'b0;
   logic        gie = 1'b0, ack = 1'b0, rdy_q, hreadyout, wa, xe, ee, ia;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q, q;
   logic [9:0]  regs [8] = '{`ATC_IDX_FLAGS, `ATC_IDX_MASK, `ATC_IDX_CTRL_A, `ATC_IDX_CTRL_B,
                             `ATC_IDX_COUNTER, `ATC_IDX_CMP_A, `ATC_IDX_CMP_B, `ATC_IDX_ASYNC};
   int          dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   int          fail_count = 0, check_count = 0;
   // Clock, and the bus answer as the master sees it at each rising edge
   always #2.5 hclk = ~hclk;
   always @(posedge hclk) {rdy_q, rd_q} <= {hreadyout, hrdata};
   atc_timer u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .async_osc_pin(osc), .wave_out_a(wa),
      .wave_out_b(), .wave_drive_a(), .wave_drive_b(), .xtal_osc_enable(xe),
      .ext_clock_buffer_enable(ee), .global_irq_enable(gie), .vector_ack_a(1'b0),
      .vector_ack_b(1'b0), .vector_ack_ovf(ack), .irq_match_a(ia), .irq_match_b(),
      .irq_overflow());
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   // Single transfer; caller sits 1 ns past an edge, so #5 lands just past the next one
   task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
      int n = 0;
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 20'h0, idx, 2'b00};
      do #5; while (rdy_q !== 1'b1 && ++n < 20);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
      do #5; while (rdy_q !== 1'b1 && ++n < 40);
      q = rd_q;
      fail_count += int'(n >= 20);
      if (n >= 20) stop_test();
   endtask : bus
   task automatic rd(input logic [9:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      `CHK($sformatf("reg %h", idx), {24'h0, e}, q)
   endtask : rd
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      foreach (regs[i]) rd(regs[i], 8'h00);
      // Forced toggle acts at once and sets no flag; in fast PWM a forced clear is ignored
      bus(1'b1, `ATC_IDX_CTRL_A, 8'h40);
      bus(1'b1, `ATC_IDX_CTRL_B, 8'hf8);
      rd(`ATC_IDX_CTRL_B, 8'h08);
      rd(`ATC_IDX_FLAGS, 8'h00);
      `CHK("wave_out_a", 1'b1, wa)
      bus(1'b1, `ATC_IDX_CTRL_A, 8'h83);
      bus(1'b1, `ATC_IDX_CTRL_B, 8'h80);
      rd(`ATC_IDX_CTRL_A, 8'h83);
      `CHK("wave_out_a held", 1'b1, wa)
      bus(1'b1, `ATC_IDX_CTRL_A, 8'h00);
      // Free prescaler phase leaves one step of slack; bus overhead adds a few at code 1
      for (int k = 1; k < 8; k++) begin
         bus(1'b1, `ATC_IDX_COUNTER, 8'h00);
         bus(1'b1, `ATC_IDX_CTRL_B, 8'(k));
         #(40 * dv[k]);
         bus(1'b1, `ATC_IDX_CTRL_B, 8'h00);
         bus(1'b0, `ATC_IDX_COUNTER, 8'h00);
         `CHK("count step", 1'b1, q >= 7 && q <= 12)
      end
      // Matches and overflow raise flags; requests need mask and global enable
      bus(1'b1, `ATC_IDX_CMP_A, 8'h20);
      bus(1'b1, `ATC_IDX_CMP_B, 8'h30);
      bus(1'b1, `ATC_IDX_MASK, 8'h03);
      bus(1'b1, `ATC_IDX_COUNTER, 8'h1e);
      gie <= 1'b1;
      bus(1'b1, `ATC_IDX_CTRL_B, 8'h01);
      #1500;
      bus(1'b1, `ATC_IDX_CTRL_B, 8'h00);
      rd(`ATC_IDX_FLAGS, 8'h07);
      `CHK("irq_match_a", 1'b1, ia)
      bus(1'b1, `ATC_IDX_FLAGS, 8'h02);
      ack <= 1'b1;
      #5;
      ack <= 1'b0;
      rd(`ATC_IDX_FLAGS, 8'h04);
      // A counter load hides the match on the very next count
      bus(1'b1, `ATC_IDX_CMP_A, 8'h40);
      bus(1'b1, `ATC_IDX_COUNTER, 8'h40);
      bus(1'b1, `ATC_IDX_CTRL_B, 8'h01);
      bus(1'b1, `ATC_IDX_CTRL_B, 8'h00);
      rd(`ATC_IDX_FLAGS, 8'h04);
      gie <= 1'b0;
      // Async writes wait in holding storage until an oscillator edge
      bus(1'b1, `ATC_IDX_ASYNC, 8'h40);
      bus(1'b1, `ATC_IDX_ASYNC, 8'hff);
      bus(1'b1, `ATC_IDX_CMP_A, 8'h55);
      rd(`ATC_IDX_ASYNC, 8'h68);
      rd(`ATC_IDX_CMP_A, 8'h55);
      `CHK("ext clock buffer", 1'b1, ee)
      osc <= 1'b1;
      #15;
      rd(`ATC_IDX_ASYNC, 8'h60);
      bus(1'b1, `ATC_IDX_ASYNC, 8'h20);
      rd(`ATC_IDX_ASYNC, 8'h20);
      `CHK("crystal enable", 1'b1, xe)
      stop_test();
   end
endmodule : test_async_timer2_control_regs
`default_nettype wire
